// ---- design/ipf_irq_priority.sv ----
// Purpose: priority level registers, vector base and fast interrupt selection
// Assumes: request inputs come from logic on clk_i; registers on a strobe port
// Notes:   winner is re-evaluated every cycle and presented one cycle later
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// Overview of operation
// - field code 00 disables source; 01, 10, 11 give levels 0, 1, 2
// - reset clears every priority field to the disabled code
// - unimplemented register bits read zero and ignore writes
// - timer C register: channel 2 in bits 3-2, channel 1 in bits 1-0
// - offset 8: serial0 rx full 15-14, rx error 13-12, tx idle 9-8, tx empty 7-6
// - offset 8: timer A channel 3 in 5-4, channel 2 in 3-2, channel 1 in 1-0
// - offset 9: pwm fault 15-14, pwm reload 11-10, bits 13-12 reserved
// - offset 9: zero cross 7-6, conversion done 3-2, others reserved
// - vector base keeps 13 bits, forms upper 13 bits of vector address
// - low vector address byte comes from the winning request identity
// - fast-0 select keeps 7-bit vector number; matching request is fast 0
// - fast requests branch straight to their stored target address
// - fast source beats every non-fast level-2 request
// - fast 0 is serviced before fast 1 when both pend
// - fast-0 target is 21 bits: 16-bit low plus 5-bit high field
module ipf_irq_priority #(
	parameter logic [6:0] VEC_FIRST = ipf_pkg::DEF_VEC_FIRST
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        sys_rst_i,
	// register port
	input  wire logic [ipf_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [ipf_pkg::DATA_W-1:0]  reg_wdata_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	output logic      [ipf_pkg::DATA_W-1:0]  reg_rdata_o,
	// peripheral requests
	input  wire logic [ipf_pkg::NUM_SRC-1:0] irq_req_i,
	// core side
	output logic                             irq_valid_o,
	output logic      [1:0]                  irq_level_o,
	output logic      [ipf_pkg::FSEL_W-1:0]  irq_vector_o,
	output logic      [ipf_pkg::TGT_W-1:0]   irq_vector_addr_o,
	output logic                             irq_fast_o,
	output logic                             irq_fast_one_o
);

	// ==========================================================
	// configuration state
	logic [1:0]                     lvl [ipf_pkg::NUM_SRC];
	logic [ipf_pkg::VBA_W-1:0]      vector_table_origin;
	logic [ipf_pkg::FSEL_W-1:0]     fast_irq_zero_select;
	logic [ipf_pkg::TGT_LO_W-1:0]   fast_irq_zero_target_low;
	logic [ipf_pkg::TGT_HI_W-1:0]   fast_irq_zero_target_high;
	logic [ipf_pkg::FSEL_W-1:0]     fast_irq_one_select;
	logic [ipf_pkg::TGT_LO_W-1:0]   fast_irq_one_target_low;
	logic [ipf_pkg::TGT_HI_W-1:0]   fast_irq_one_target_high;

	logic [ipf_pkg::FSEL_W-1:0]     src_vec  [ipf_pkg::NUM_SRC];
	logic [3:0]                     src_rank [ipf_pkg::NUM_SRC];
	logic [ipf_pkg::NUM_SRC-1:0]    pend;
	logic [ipf_pkg::NUM_SRC-1:0]    is_f0;
	logic [ipf_pkg::NUM_SRC-1:0]    is_f1;
	logic [ipf_pkg::DATA_W-1:0]     next_rdata;
	logic                           next_valid;
	logic [3:0]                     next_idx;
	logic [3:0]                     best_rank;

	logic wr_hit;
	assign wr_hit = reg_wr_i;

	// ==========================================================
	// per source level fields, decode and ranking
	genvar g;
	generate
		for (g = 0; g < ipf_pkg::NUM_SRC; g++) begin : g_src
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					lvl[g] <= ipf_pkg::LVL_OFF;
				end else if (wr_hit && reg_addr_i == ipf_pkg::SRC_REG[g]) begin
					lvl[g] <= reg_wdata_i[ipf_pkg::SRC_POS[g] +: ipf_pkg::LVL_W];
				end
			end
			assign src_vec[g] = VEC_FIRST + 7'(g);
			// 00 means disabled: such a source never pends
			assign pend[g]  = irq_req_i[g] && (lvl[g] != ipf_pkg::LVL_OFF);
			assign is_f0[g] = pend[g] && (src_vec[g] == fast_irq_zero_select);
			assign is_f1[g] = pend[g] && (src_vec[g] == fast_irq_one_select);
			// fast flags above the level code lift a fast source over level 2
			assign src_rank[g] = {is_f0[g], is_f1[g] && !is_f0[g], lvl[g]};
		end
	endgenerate

	// ==========================================================
	// vector base and fast interrupt registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			vector_table_origin <= ipf_pkg::RST_VBA;
		end else if (wr_hit && reg_addr_i == ipf_pkg::OFS_VBA) begin
			vector_table_origin <= reg_wdata_i[ipf_pkg::VBA_POS +: ipf_pkg::VBA_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fast_irq_zero_select      <= ipf_pkg::RST_FSEL;
			fast_irq_zero_target_low  <= ipf_pkg::RST_TGT_LO;
			fast_irq_zero_target_high <= ipf_pkg::RST_TGT_HI;
		end else if (wr_hit) begin
			if (reg_addr_i == ipf_pkg::OFS_FAST0_SEL) begin
				fast_irq_zero_select <= reg_wdata_i[ipf_pkg::FSEL_POS +: ipf_pkg::FSEL_W];
			end else if (reg_addr_i == ipf_pkg::OFS_FAST0_LOW) begin
				fast_irq_zero_target_low <= reg_wdata_i;
			end else if (reg_addr_i == ipf_pkg::OFS_FAST0_HIGH) begin
				fast_irq_zero_target_high <= reg_wdata_i[ipf_pkg::TGT_POS +: ipf_pkg::TGT_HI_W];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fast_irq_one_select      <= ipf_pkg::RST_FSEL;
			fast_irq_one_target_low  <= ipf_pkg::RST_TGT_LO;
			fast_irq_one_target_high <= ipf_pkg::RST_TGT_HI;
		end else if (wr_hit) begin
			if (reg_addr_i == ipf_pkg::OFS_FAST1_SEL) begin
				fast_irq_one_select <= reg_wdata_i[ipf_pkg::FSEL_POS +: ipf_pkg::FSEL_W];
			end else if (reg_addr_i == ipf_pkg::OFS_FAST1_LOW) begin
				fast_irq_one_target_low <= reg_wdata_i;
			end else if (reg_addr_i == ipf_pkg::OFS_FAST1_HIGH) begin
				fast_irq_one_target_high <= reg_wdata_i[ipf_pkg::TGT_POS +: ipf_pkg::TGT_HI_W];
			end
		end
	end

	// ==========================================================
	// read mux: only implemented bits are ever set
	always_comb begin
		next_rdata = '0;
		if (reg_addr_i == ipf_pkg::OFS_VBA) begin
			next_rdata[ipf_pkg::VBA_POS +: ipf_pkg::VBA_W] = vector_table_origin;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST0_SEL) begin
			next_rdata[ipf_pkg::FSEL_POS +: ipf_pkg::FSEL_W] = fast_irq_zero_select;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST0_LOW) begin
			next_rdata = fast_irq_zero_target_low;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST0_HIGH) begin
			next_rdata[ipf_pkg::TGT_POS +: ipf_pkg::TGT_HI_W] = fast_irq_zero_target_high;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST1_SEL) begin
			next_rdata[ipf_pkg::FSEL_POS +: ipf_pkg::FSEL_W] = fast_irq_one_select;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST1_LOW) begin
			next_rdata = fast_irq_one_target_low;
		end else if (reg_addr_i == ipf_pkg::OFS_FAST1_HIGH) begin
			next_rdata[ipf_pkg::TGT_POS +: ipf_pkg::TGT_HI_W] = fast_irq_one_target_high;
		end else begin
			for (int i = 0; i < ipf_pkg::NUM_SRC; i++) begin
				if (reg_addr_i == ipf_pkg::SRC_REG[i]) begin
					next_rdata[ipf_pkg::SRC_POS[i] +: ipf_pkg::LVL_W] = lvl[i];
				end
			end
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ==========================================================
	// arbitration
	// scanning from the top index with >= lets the lowest index win ties
	always_comb begin
		next_valid = 1'b0;
		next_idx   = 4'h0;
		best_rank  = 4'h0;
		for (int i = ipf_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pend[i] && src_rank[i] >= best_rank) begin
				next_valid = 1'b1;
				next_idx   = 4'(i);
				best_rank  = src_rank[i];
			end
		end
	end

	// ==========================================================
	// core side outputs, refreshed every cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_valid_o       <= 1'b0;
			irq_level_o       <= 2'h0;
			irq_vector_o      <= 7'h00;
			irq_vector_addr_o <= 21'h000000;
			irq_fast_o        <= 1'b0;
			irq_fast_one_o    <= 1'b0;
		end else begin
			irq_valid_o    <= next_valid;
			irq_level_o    <= next_valid ? lvl[next_idx] - 2'h1 : 2'h0;
			irq_vector_o   <= next_valid ? src_vec[next_idx] : 7'h00;
			irq_fast_o     <= next_valid && (best_rank[3] || best_rank[2]);
			irq_fast_one_o <= next_valid && !best_rank[3] && best_rank[2];
			if (!next_valid) begin
				irq_vector_addr_o <= 21'h000000;
			end else if (best_rank[3]) begin
				// fast path skips the jump table entirely
				irq_vector_addr_o <= {fast_irq_zero_target_high, fast_irq_zero_target_low};
			end else if (best_rank[2]) begin
				irq_vector_addr_o <= {fast_irq_one_target_high, fast_irq_one_target_low};
			end else begin
				irq_vector_addr_o <= {vector_table_origin,
					src_vec[next_idx], 1'b0};
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic [ipf_pkg::NUM_SRC-1:0] lvl_any;
	logic [ipf_pkg::NUM_SRC-1:0] pend_q;
	logic [ipf_pkg::NUM_SRC-1:0] beaten;
	logic [1:0]                  lvl_q [ipf_pkg::NUM_SRC];
	logic [3:0]                  win_idx;
	logic [1:0]                  win_lvl;

	// the grant is registered, so it is judged against last cycle's state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend;
		end
	end

	assign win_idx = 4'(irq_vector_o - VEC_FIRST);
	// an index past the last source only appears while nothing is granted
	assign win_lvl = (win_idx < 4'(ipf_pkg::NUM_SRC)) ? lvl_q[win_idx] : ipf_pkg::LVL_OFF;

	generate
		for (g = 0; g < ipf_pkg::NUM_SRC; g++) begin : g_chk
			assign lvl_any[g] = |lvl[g];
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					lvl_q[g] <= ipf_pkg::LVL_OFF;
				end else begin
					lvl_q[g] <= lvl[g];
				end
			end
			// set where a pending source should have won over the presented one
			assign beaten[g] = pend_q[g] && ((lvl_q[g] > win_lvl)
				|| (lvl_q[g] == win_lvl && 4'(g) < win_idx));
		end
	endgenerate

	chk_reset_levels_off: assert property (
		@(posedge clk_i) disable iff (1'b0) sys_rst_i |=> (lvl_any == '0 && !irq_valid_o)
	) else $error("priority field not disabled after reset");

	chk_reserved_reads_zero: assert property (
		reg_rd_i && reg_addr_i == ipf_pkg::OFS_PWM_ADC
		|=> (reg_rdata_o & 16'h3333) == 16'h0000
	) else $error("reserved bits read nonzero");

	chk_disabled_no_grant: assert property (
		irq_valid_o |-> win_lvl != ipf_pkg::LVL_OFF
	) else $error("disabled source was granted");

	chk_vba_upper_bits: assert property (
		irq_valid_o && !irq_fast_o
		|-> irq_vector_addr_o[20:8] == $past(vector_table_origin)
	) else $error("vector base not in upper address bits");

	chk_low_byte_ident: assert property (
		irq_valid_o && !irq_fast_o |-> irq_vector_addr_o[7:0] == {irq_vector_o, 1'b0}
	) else $error("low vector byte does not match winner");

	chk_fast0_target: assert property (
		irq_fast_o && !irq_fast_one_o
		|-> irq_vector_addr_o == $past({fast_irq_zero_target_high, fast_irq_zero_target_low})
	) else $error("fast 0 target address wrong");

	chk_fast_select_write: assert property (
		reg_wr_i && reg_addr_i == ipf_pkg::OFS_FAST0_SEL
		|=> fast_irq_zero_select == $past(reg_wdata_i[6:0])
	) else $error("fast 0 select not stored");

	chk_fast0_over_fast1: assert property (
		(|is_f0) && (|is_f1) |=> irq_fast_o && !irq_fast_one_o
	) else $error("fast 1 serviced ahead of fast 0");

	chk_fast_beats_level2: assert property (
		(|is_f0) |=> irq_fast_o ##0 irq_vector_o == $past(fast_irq_zero_select)
	) else $error("fast source lost to a normal request");

	chk_level_code_map: assert property (
		irq_valid_o |-> {1'b0, irq_level_o} + 3'h1 == {1'b0, win_lvl}
	) else $error("granted level does not follow field code");

	chk_grant_tracks_pend: assert property (
		irq_valid_o == (|pend_q)
	) else $error("grant presence differs from pending requests");

	chk_lowest_wins_tie: assert property (
		irq_valid_o && !irq_fast_o |-> beaten == '0
	) else $error("a stronger or lower numbered request was passed over");

	chk_idle_outputs_zero: assert property (
		!irq_valid_o |-> irq_level_o == 2'h0 && irq_vector_o == 7'h00
			&& irq_vector_addr_o == 21'h000000 && !irq_fast_o && !irq_fast_one_o
	) else $error("core side not cleared while idle");

	chk_fast1_target: assert property (
		irq_fast_one_o
		|-> irq_vector_addr_o == $past({fast_irq_one_target_high, fast_irq_one_target_low})
	) else $error("fast 1 target address wrong");

	chk_fast_one_flag: assert property (
		irq_fast_one_o |-> irq_fast_o
	) else $error("fast 1 flagged without fast flag");

	chk_read_idle_zero: assert property (
		!reg_rd_i |=> reg_rdata_o == 16'h0000
	) else $error("read data present without a read strobe");

	chk_vba_read_back: assert property (
		reg_rd_i && reg_addr_i == ipf_pkg::OFS_VBA
		|=> reg_rdata_o == {3'h0, $past(vector_table_origin)}
	) else $error("vector base read back wrong");

	chk_timer_c_reserved: assert property (
		reg_rd_i && reg_addr_i == ipf_pkg::OFS_TIMER_C
		|=> reg_rdata_o[15:4] == 12'h000
	) else $error("timer C reserved bits read nonzero");

	chk_serial_reserved: assert property (
		reg_rd_i && reg_addr_i == ipf_pkg::OFS_SERIAL0_TA
		|=> reg_rdata_o[11:10] == 2'h0
	) else $error("serial reserved bits read nonzero");

	chk_target_high_reserved: assert property (
		reg_rd_i && reg_addr_i == ipf_pkg::OFS_FAST0_HIGH
		|=> reg_rdata_o[15:5] == 11'h000
	) else $error("fast 0 high target reserved bits read nonzero");

	chk_vba_write_masked: assert property (
		reg_wr_i && reg_addr_i == ipf_pkg::OFS_VBA
		|=> vector_table_origin == $past(reg_wdata_i[12:0])
	) else $error("vector base not stored");

endmodule

// ---- design/ipf_pkg.sv ----
// Purpose: shared constants of the interrupt priority and fast vector block
// Assumes: 16-bit registers at word offsets on a plain strobe port
// Notes:   source order below fixes vector numbering and tie breaking
package ipf_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W  = 5;
	localparam int DATA_W  = 16;
	localparam int NUM_SRC = 13;

	// ==========================================================
	// register offsets
	localparam logic [4:0] OFS_TIMER_C    = 5'h07;
	localparam logic [4:0] OFS_SERIAL0_TA = 5'h08;
	localparam logic [4:0] OFS_PWM_ADC    = 5'h09;
	localparam logic [4:0] OFS_VBA        = 5'h0A;
	localparam logic [4:0] OFS_FAST0_SEL  = 5'h0B;
	localparam logic [4:0] OFS_FAST0_LOW  = 5'h0C;
	localparam logic [4:0] OFS_FAST0_HIGH = 5'h0D;
	localparam logic [4:0] OFS_FAST1_SEL  = 5'h0E;
	localparam logic [4:0] OFS_FAST1_LOW  = 5'h0F;
	localparam logic [4:0] OFS_FAST1_HIGH = 5'h10;

	// ==========================================================
	// field widths and positions
	localparam int VBA_W    = 13;
	localparam int FSEL_W   = 7;
	localparam int TGT_LO_W = 16;
	localparam int TGT_HI_W = 5;
	localparam int TGT_W    = 21;
	localparam int LVL_W    = 2;
	localparam int VBA_POS  = 0;
	localparam int FSEL_POS = 0;
	localparam int TGT_POS  = 0;
	localparam int LOWB_SHIFT = 1;

	// ==========================================================
	// reset values and level codes
	localparam logic [1:0]  LVL_OFF     = 2'h0;
	localparam logic [1:0]  LVL_TOP     = 2'h3;
	localparam logic [12:0] RST_VBA     = 13'h0000;
	localparam logic [6:0]  RST_FSEL    = 7'h00;
	localparam logic [15:0] RST_TGT_LO  = 16'h0000;
	localparam logic [4:0]  RST_TGT_HI  = 5'h00;
	localparam logic [6:0]  DEF_VEC_FIRST = 7'h28;

	// ==========================================================
	// source map: 0 timer C ch1, 1 timer C ch2, 2..4 timer A ch1..3,
	// 5 serial0 tx empty, 6 tx idle, 7 rx error, 8 rx full,
	// 9 converter done, 10 zero cross, 11 pwm reload, 12 pwm fault
	localparam logic [4:0] SRC_REG [NUM_SRC] = '{
		OFS_TIMER_C, OFS_TIMER_C,
		OFS_SERIAL0_TA, OFS_SERIAL0_TA, OFS_SERIAL0_TA,
		OFS_SERIAL0_TA, OFS_SERIAL0_TA, OFS_SERIAL0_TA, OFS_SERIAL0_TA,
		OFS_PWM_ADC, OFS_PWM_ADC, OFS_PWM_ADC, OFS_PWM_ADC
	};
	localparam logic [3:0] SRC_POS [NUM_SRC] = '{
		4'h0, 4'h2,
		4'h0, 4'h2, 4'h4,
		4'h6, 4'h8, 4'hC, 4'hE,
		4'h2, 4'h6, 4'hA, 4'hE
	};

endpackage

// ---- testbench/ipf_core_model.sv ----
// Purpose: stand-in for the processor core that takes granted vectors
// Assumes: no acknowledge path; the core just follows what is presented
// Notes:   keeps the last taken address so the bench can see what a core saw
`timescale 1ns/1ps
module ipf_core_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// granted request
	input  wire logic        valid_i,
	input  wire logic [20:0] addr_i,
	// what the core took
	output logic      [20:0] taken_addr_o
);
	// ==========================================================
	// capture
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			taken_addr_o <= 21'h000000;
		end else if (valid_i) begin
			taken_addr_o <= addr_i;
		end
	end
endmodule

// ---- testbench/irq_priority_and_fast_vector_tb_top.sv ----
// Purpose: self-checking bench for the priority and fast vector block
// Assumes: request lines and register port driven on the rising edge
// Notes:   vector base kept nonzero so address bits are really exercised
`timescale 1ns/1ps
module irq_priority_and_fast_vector_tb_top;
	// ==========================================================
	// signals
	localparam logic [6:0] VF = 7'h10;
	logic        clk_i       = 1'b0;
	logic        sys_rst_i   = 1'b1;
	logic [4:0]  reg_addr_i  = 5'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [12:0] irq_req_i   = 13'h0000;
	logic [15:0] reg_rdata_o;
	logic        irq_valid_o, irq_fast_o, irq_fast_one_o;
	logic [1:0]  irq_level_o;
	logic [6:0]  irq_vector_o;
	logic [20:0] irq_vector_addr_o, taken_addr;
	logic [12:0] vbase = 13'h1ABC;
	logic [3:0]  pos [13] = '{4'h0, 4'h2, 4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC, 4'hE,
		4'h2, 4'h6, 4'hA, 4'hE};
	logic [15:0] mask [10] = '{16'h000F, 16'hF3FF, 16'hCCCC, 16'h1FFF, 16'h007F,
		16'hFFFF, 16'h001F, 16'h007F, 16'hFFFF, 16'h001F};
	int          fail_count = 0;
	int          compares   = 0;
	int          cycles     = 0;

	ipf_irq_priority #(.VEC_FIRST(VF)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_req_i(irq_req_i),
		.irq_valid_o(irq_valid_o), .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o),
		.irq_vector_addr_o(irq_vector_addr_o), .irq_fast_o(irq_fast_o),
		.irq_fast_one_o(irq_fast_one_o));
	ipf_core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .valid_i(irq_valid_o),
		.addr_i(irq_vector_addr_o), .taken_addr_o(taken_addr));

	always #2 clk_i = ~clk_i;

	// ==========================================================
	// shared tasks
	task automatic stop_test();
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// timeout well above the ~600 cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("[FAIL] %0t timeout", $time);
			stop_test();
		end
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_irq(input logic v, input logic [1:0] l, input logic [6:0] n,
		input logic [20:0] a, input logic f, input logic f1);
		chk({irq_valid_o, irq_level_o, irq_vector_o, irq_vector_addr_o, irq_fast_o,
			irq_fast_one_o}, {v, l, n, a, f, f1}, "core side");
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	// data only in the cycle after the strobe, zero afterwards
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		#1 chk(33'(reg_rdata_o), 33'(exp), "read");
		@(posedge clk_i);
		#1 chk(33'(reg_rdata_o), 33'h0, "read idle");
	endtask

	task automatic wregs(input logic [15:0] r7, input logic [15:0] r8, input logic [15:0] r9);
		wr(5'h07, r7);
		wr(5'h08, r8);
		wr(5'h09, r9);
	endtask

	task automatic settle();
		@(posedge clk_i);
		@(posedge clk_i);
		#1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_values();
		for (int a = 7; a <= 16; a++) rd_chk(5'(a), 16'h0000);
		rd_chk(5'h1F, 16'h0000);
	endtask

	task automatic t_reserved();
		for (int a = 7; a <= 16; a++) begin
			wr(5'(a), 16'hFFFF);
			rd_chk(5'(a), mask[a-7]);
		end
		wr(5'h1F, 16'hFFFF);
		rd_chk(5'h1F, 16'h0000);
		for (int a = 7; a <= 16; a++) wr(5'(a), 16'h0000);
	endtask

	task automatic t_fields();
		logic [15:0] v;
		wr(5'h0A, 16'(vbase));
		for (int i = 0; i < 13; i++) begin
			for (int c = 0; c < 4; c++) begin
				v = 16'(c) << pos[i];
				wregs(i < 2 ? v : 16'h0, (i >= 2 && i < 9) ? v : 16'h0, i >= 9 ? v : 16'h0);
				irq_req_i <= 13'h0001 << i;
				settle();
				if (c == 0) chk_irq(1'b0, 2'h0, 7'h00, 21'h0, 1'b0, 1'b0);
				else chk_irq(1'b1, 2'(c - 1), VF + 7'(i), {vbase, VF + 7'(i), 1'b0},
					1'b0, 1'b0);
			end
		end
		@(posedge clk_i);
		irq_req_i <= 13'h0000;
	endtask

	task automatic t_order();
		wregs(16'h0001, 16'h0088, 16'hC000);
		irq_req_i <= 13'h0029;
		settle();
		chk_irq(1'b1, 2'h1, VF + 7'h03, {vbase, VF + 7'h03, 1'b0}, 1'b0, 1'b0);
		@(posedge clk_i);
		irq_req_i <= 13'h1029;
		settle();
		chk_irq(1'b1, 2'h2, VF + 7'h0C, {vbase, VF + 7'h0C, 1'b0}, 1'b0, 1'b0);
	endtask

	task automatic t_fast();
		wregs(16'h0000, 16'hC003, 16'h0000);
		wr(5'h0B, 16'(VF + 7'h08));
		wr(5'h0C, 16'h1234);
		wr(5'h0D, 16'h0015);
		wr(5'h0E, 16'(VF + 7'h02));
		wr(5'h0F, 16'hBEEF);
		wr(5'h10, 16'h000A);
		irq_req_i <= 13'h0104;
		settle();
		chk_irq(1'b1, 2'h2, VF + 7'h08, 21'h151234, 1'b1, 1'b0);
		chk(33'(taken_addr), 33'h151234, "core took");
		@(posedge clk_i);
		irq_req_i <= 13'h0004;
		settle();
		chk_irq(1'b1, 2'h2, VF + 7'h02, 21'h0ABEEF, 1'b1, 1'b1);
	endtask

	task automatic t_reset_mid();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		settle();
		chk_irq(1'b0, 2'h0, 7'h00, 21'h0, 1'b0, 1'b0);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		settle();
		chk_irq(1'b0, 2'h0, 7'h00, 21'h0, 1'b0, 1'b0);
		rd_chk(5'h08, 16'h0000);
		rd_chk(5'h0B, 16'h0000);
		@(posedge clk_i);
		irq_req_i <= 13'h0000;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset_values();
		t_reserved();
		t_fields();
		t_order();
		t_fast();
		t_reset_mid();
		stop_test();
	end
endmodule
